/* hdl/pgpio_consts.svh */
// constants and summary of behaviour for the upper-bank parallel gpio block
// What this block does
// R1 - both enable and direction zero: data bit reads the sampled pin level
// R2 - both enable and direction one: pin is driven to the data bit value
// R3 - software keeps enable and direction equal; mixed settings undefined
// R4 - enable zero: pin is never driven, input only
// R5 - enable one: output driver on; value defined only when direction is one
// R6 - direction zero: data bit reflects the pin level
// R7 - direction one: data bit sets the driven level
// R8 - first data register holds pins 16 to 31 in bits 15 down to 0
// R9 - bank two maps pins 32-45 to bits 13-0; bits 15-14 reserved RW, reset 00
// R10 - reset clears all second-bank enable and direction bits
// R11 - data bits reset to the pin level present at reset
// R12 - pin levels pass two flip-flops before reaching data reads
`ifndef PGPIO_CONSTS_SVH
`define PGPIO_CONSTS_SVH
`define PGPIO_ADDR_W        16
`define PGPIO_DATA_W        16
`define PGPIO_BANK1_PINS    16
`define PGPIO_BANK2_PINS    14
`define PGPIO_OFS_EN2       16'h4406
`define PGPIO_OFS_DIR2      16'h4407
`define PGPIO_OFS_DAT2      16'h4408
`define PGPIO_OFS_DAT1      16'h4405
`define PGPIO_RST_EN2       16'h0000
`define PGPIO_RST_DIR2      16'h0000
`define PGPIO_RST_RSV       2'h0
`define PGPIO_RSV_LSB       14
`define PGPIO_RSV_MSB       15
`endif

/* hdl/pgpio_pkg.sv */
// types for the upper-bank parallel gpio block
package pgpio_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } pgpio_req_t;
   typedef struct packed {
      logic [13:0] oe;
      logic [13:0] dir;
      logic [13:0] dat;
      logic [1:0]  rsv_oe;
      logic [1:0]  rsv_dir;
      logic [1:0]  rsv_dat;
   } pgpio_bank2_t;
endpackage

/* hdl/pgpio_upper.sv */
// upper-bank parallel gpio: pins 16-31 data, pins 32-45 enable/direction/data
//
// Implementation choice: strobed register access.
`include "pgpio_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pgpio_upper (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire pgpio_pkg::pgpio_req_t bus_req,
   output logic [15:0]              bus_rdata,
   input  wire logic [15:0]         bank1_pin_i,
   output logic [15:0]              bank1_pin_o,
   output logic [15:0]              bank1_pin_oe,
   input  wire logic [13:0]         bank2_pin_i,
   output logic [13:0]              bank2_pin_o,
   output logic [13:0]              bank2_pin_oe,
   input  wire logic [15:0]         bank1_oe_cfg,
   input  wire logic [15:0]         bank1_dir_cfg
);
   // bank1 enable/direction live outside this block; they arrive as plain inputs
   logic [15:0] s1a_q, s1b_q;
   logic [13:0] s2a_q, s2b_q;
   logic [15:0] dat1_q, dat1_d;
   pgpio_pkg::pgpio_bank2_t b2_q, b2_d;
   logic [15:0] rdata_q, rdata_d;
   logic        init_q;

   wire wr = bus_req.wr;
   wire rd = bus_req.rd;

   // two-stage synchronisers; only the second stage is read
   always_ff @(posedge ref_clk) begin
      s1a_q <= bank1_pin_i; // R12
      s1b_q <= s1a_q;
      s2a_q <= bank2_pin_i; // R12
      s2b_q <= s2a_q;
   end

   always_comb begin
      dat1_d = dat1_q;
      b2_d   = b2_q;
      // after reset, data bits load the synchronised pin level once
      if (init_q) begin
         dat1_d     = s1b_q; // R11
         b2_d.dat   = s2b_q; // R11
      end
      // input bits track the pin; output bits keep what software wrote
      for (int i = 0; i < 16; i++) begin
         if (!bank1_dir_cfg[i] && !init_q)
            dat1_d[i] = s1b_q[i]; // R6 R1
      end
      for (int i = 0; i < 14; i++) begin
         if (!b2_q.dir[i] && !init_q)
            b2_d.dat[i] = s2b_q[i]; // R6 R1
      end
      if (wr) begin
         unique case (bus_req.addr)
            `PGPIO_OFS_DAT1: begin
               for (int i = 0; i < 16; i++)
                  if (bank1_dir_cfg[i])
                     dat1_d[i] = bus_req.wdata[i]; // R7 R8
            end
            `PGPIO_OFS_EN2: begin
               b2_d.oe     = bus_req.wdata[13:0]; // R9
               b2_d.rsv_oe = bus_req.wdata[`PGPIO_RSV_MSB:`PGPIO_RSV_LSB];
            end
            `PGPIO_OFS_DIR2: begin
               b2_d.dir     = bus_req.wdata[13:0]; // R9
               b2_d.rsv_dir = bus_req.wdata[`PGPIO_RSV_MSB:`PGPIO_RSV_LSB];
            end
            `PGPIO_OFS_DAT2: begin
               b2_d.rsv_dat = bus_req.wdata[`PGPIO_RSV_MSB:`PGPIO_RSV_LSB];
               for (int i = 0; i < 14; i++)
                  if (b2_q.dir[i])
                     b2_d.dat[i] = bus_req.wdata[i]; // R7 R9
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         init_q       <= 1'b1;
         dat1_q       <= 16'h0000;
         b2_q.oe      <= 14'h0000; // R10
         b2_q.dir     <= 14'h0000; // R10
         b2_q.dat     <= 14'h0000;
         b2_q.rsv_oe  <= `PGPIO_RST_RSV; // R9
         b2_q.rsv_dir <= `PGPIO_RST_RSV;
         b2_q.rsv_dat <= `PGPIO_RST_RSV;
      end else begin
         init_q <= 1'b0;
         dat1_q <= dat1_d;
         b2_q   <= b2_d;
      end
   end

   always_comb begin
      rdata_d = 16'h0000;
      if (rd) begin
         unique case (bus_req.addr)
            `PGPIO_OFS_DAT1: rdata_d = dat1_d; // R8
            `PGPIO_OFS_EN2:  rdata_d = {b2_q.rsv_oe, b2_q.oe};
            `PGPIO_OFS_DIR2: rdata_d = {b2_q.rsv_dir, b2_q.dir};
            `PGPIO_OFS_DAT2: rdata_d = {b2_q.rsv_dat, b2_d.dat};
            default:         rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         rdata_q <= 16'h0000;
      else
         rdata_q <= rdata_d;
   end
   assign bus_rdata = rdata_q;

   // driver only on when enable set; level follows data (defined when dir=1)
   assign bank1_pin_oe = bank1_oe_cfg; // R4 R5
   assign bank1_pin_o  = dat1_q; // R2
   assign bank2_pin_oe = b2_q.oe; // R4 R5
   assign bank2_pin_o  = b2_q.dat; // R2

   // reset clears bank2 drive and direction, reserved bits and read data
   property p_en2_reset;
      @(posedge ref_clk) rst |=> (b2_q.oe == 14'h0000 && b2_q.dir == 14'h0000);
   endproperty
   a_en2_reset: assert property (p_en2_reset) else $error("bank2 enable/direction not cleared"); // R10

   property p_rsv_reset;
      @(posedge ref_clk) rst |=> (b2_q.rsv_oe == 2'h0 && b2_q.rsv_dir == 2'h0 && b2_q.rsv_dat == 2'h0);
   endproperty
   a_rsv_reset: assert property (p_rsv_reset) else $error("reserved bits not cleared"); // R9

   property p_rdata_reset;
      @(posedge ref_clk) rst |=> (bus_rdata == 16'h0000);
   endproperty
   a_rdata_reset: assert property (p_rdata_reset) else $error("read data not cleared"); // R10

   // first edge after reset loads the synchronised pin level
   property p_init_load1;
      @(posedge ref_clk) disable iff (rst)
         (init_q && !wr) |=> dat1_q == $past(s1b_q);
   endproperty
   a_init_load1: assert property (p_init_load1) else $error("bank1 data not loaded from pins"); // R11

   property p_init_load2;
      @(posedge ref_clk) disable iff (rst)
         (init_q && !wr) |=> b2_q.dat == $past(s2b_q);
   endproperty
   a_init_load2: assert property (p_init_load2) else $error("bank2 data not loaded from pins"); // R11

   // both synchronisers are exactly two stages deep
   property p_sync_depth;
      @(posedge ref_clk) disable iff (rst) ##2 (s2b_q == $past(bank2_pin_i, 2));
   endproperty
   a_sync_depth: assert property (p_sync_depth) else $error("sync depth wrong"); // R12

   property p_sync1_depth;
      @(posedge ref_clk) disable iff (rst) ##2 (s1b_q == $past(bank1_pin_i, 2));
   endproperty
   a_sync1_depth: assert property (p_sync1_depth) else $error("bank1 sync depth wrong"); // R12

   // input bits follow the pin and ignore software writes
   property p_input_track;
      @(posedge ref_clk) disable iff (rst)
         (!b2_q.dir[0] && !init_q && !$past(rst)) ##1 !b2_q.dir[0] |-> b2_q.dat[0] == $past(s2b_q[0]);
   endproperty
   a_input_track: assert property (p_input_track) else $error("bank2 input bit stale"); // R6

   property p_dat1_track;
      @(posedge ref_clk) disable iff (rst)
         (!bank1_dir_cfg[3] && !init_q) |=> dat1_q[3] == $past(s1b_q[3]);
   endproperty
   a_dat1_track: assert property (p_dat1_track) else $error("bank1 input bit stale"); // R6

   property p_input_top;
      @(posedge ref_clk) disable iff (rst)
         (!b2_q.dir[13] && !init_q) |=> b2_q.dat[13] == $past(s2b_q[13]);
   endproperty
   a_input_top: assert property (p_input_top) else $error("bank2 top input bit stale"); // R1

   property p_in_ignores_write;
      @(posedge ref_clk) disable iff (rst)
         (wr && bus_req.addr == `PGPIO_OFS_DAT2 && !b2_q.dir[0] && !init_q) |=> b2_q.dat[0] == $past(s2b_q[0]);
   endproperty
   a_in_ignores_write: assert property (p_in_ignores_write) else $error("input bit took a write"); // R6

   // writes land on the next edge
   property p_out_write;
      @(posedge ref_clk) disable iff (rst)
         (wr && bus_req.addr == `PGPIO_OFS_DAT2 && b2_q.dir[0] && !init_q) |=> b2_q.dat[0] == $past(bus_req.wdata[0]);
   endproperty
   a_out_write: assert property (p_out_write) else $error("output data write lost"); // R7

   property p_out_bit1;
      @(posedge ref_clk) disable iff (rst)
         (wr && bus_req.addr == `PGPIO_OFS_DAT2 && b2_q.dir[1] && !init_q) |=> b2_q.dat[1] == $past(bus_req.wdata[1]);
   endproperty
   a_out_bit1: assert property (p_out_bit1) else $error("output bit1 write lost"); // R7

   property p_en2_write;
      @(posedge ref_clk) disable iff (rst)
         (wr && bus_req.addr == `PGPIO_OFS_EN2) |=> b2_q.oe == $past(bus_req.wdata[13:0]);
   endproperty
   a_en2_write: assert property (p_en2_write) else $error("enable write lost"); // R9

   property p_dir2_write;
      @(posedge ref_clk) disable iff (rst)
         (wr && bus_req.addr == `PGPIO_OFS_DIR2) |=> b2_q.dir == $past(bus_req.wdata[13:0]);
   endproperty
   a_dir2_write: assert property (p_dir2_write) else $error("direction write lost"); // R9

   property p_rsv_rw;
      @(posedge ref_clk) disable iff (rst)
         (wr && bus_req.addr == `PGPIO_OFS_EN2) |=> b2_q.rsv_oe == $past(bus_req.wdata[15:14]);
   endproperty
   a_rsv_rw: assert property (p_rsv_rw) else $error("reserved bits not writable"); // R9

   property p_rsv_dir_rw;
      @(posedge ref_clk) disable iff (rst)
         (wr && bus_req.addr == `PGPIO_OFS_DIR2) |=> b2_q.rsv_dir == $past(bus_req.wdata[15:14]);
   endproperty
   a_rsv_dir_rw: assert property (p_rsv_dir_rw) else $error("direction reserved bits not writable"); // R9

   property p_rsv_dat_rw;
      @(posedge ref_clk) disable iff (rst)
         (wr && bus_req.addr == `PGPIO_OFS_DAT2) |=> b2_q.rsv_dat == $past(bus_req.wdata[15:14]);
   endproperty
   a_rsv_dat_rw: assert property (p_rsv_dat_rw) else $error("data reserved bits not writable"); // R9

   property p_dat1_out_write;
      @(posedge ref_clk) disable iff (rst)
         (wr && bus_req.addr == `PGPIO_OFS_DAT1 && bank1_dir_cfg[0] && !init_q) |=> bank1_pin_o[0] == $past(bus_req.wdata[0]);
   endproperty
   a_dat1_out_write: assert property (p_dat1_out_write) else $error("bank1 output write lost"); // R7

   // pin side: the bank2 driver moves only on an enable write
   property p_no_drive;
      @(posedge ref_clk) disable iff (rst)
         !(wr && bus_req.addr == `PGPIO_OFS_EN2) |=> $stable(bank2_pin_oe);
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("bank2 drive enable moved"); // R4

   property p_dir_hold;
      @(posedge ref_clk) disable iff (rst)
         !(wr && bus_req.addr == `PGPIO_OFS_DIR2) |=> $stable(b2_q.dir);
   endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("bank2 direction moved"); // R7

   property p_drive_level;
      @(posedge ref_clk) disable iff (rst)
         (wr && bus_req.addr == `PGPIO_OFS_DAT2 && b2_q.oe[0] && b2_q.dir[0] && !init_q) |=> bank2_pin_o[0] == $past(bus_req.wdata[0]);
   endproperty
   a_drive_level: assert property (p_drive_level) else $error("bank2 pin0 level wrong"); // R2

   property p_oe_write_drive;
      @(posedge ref_clk) disable iff (rst)
         (wr && bus_req.addr == `PGPIO_OFS_EN2) |=> bank2_pin_oe == $past(bus_req.wdata[13:0]);
   endproperty
   a_oe_write_drive: assert property (p_oe_write_drive) else $error("bank2 driver not switched"); // R5

   // read data stand one cycle after the strobe, zero otherwise
   property p_read_dir;
      @(posedge ref_clk) disable iff (rst)
         (rd && bus_req.addr == `PGPIO_OFS_DIR2 && !wr) |=> bus_rdata == $past({b2_q.rsv_dir, b2_q.dir});
   endproperty
   a_read_dir: assert property (p_read_dir) else $error("direction readback wrong"); // R9

   property p_read_en;
      @(posedge ref_clk) disable iff (rst)
         (rd && bus_req.addr == `PGPIO_OFS_EN2) |=> bus_rdata == $past({b2_q.rsv_oe, b2_q.oe});
   endproperty
   a_read_en: assert property (p_read_en) else $error("enable readback wrong"); // R9

   property p_read_rsv_dat;
      @(posedge ref_clk) disable iff (rst)
         (rd && bus_req.addr == `PGPIO_OFS_DAT2) |=> bus_rdata[15:14] == $past(b2_q.rsv_dat);
   endproperty
   a_read_rsv_dat: assert property (p_read_rsv_dat) else $error("data reserved readback wrong"); // R9

   property p_dat1_in;
      @(posedge ref_clk) disable iff (rst)
         (rd && bus_req.addr == `PGPIO_OFS_DAT1 && !init_q && !bank1_dir_cfg[3]) |=> bus_rdata[3] == $past(s1b_q[3]);
   endproperty
   a_dat1_in: assert property (p_dat1_in) else $error("bank1 input read wrong"); // R1

   property p_dat1_read_out;
      @(posedge ref_clk) disable iff (rst)
         (rd && !wr && bus_req.addr == `PGPIO_OFS_DAT1 && bank1_dir_cfg[0]) |=> bus_rdata[0] == $past(dat1_q[0]);
   endproperty
   a_dat1_read_out: assert property (p_dat1_read_out) else $error("bank1 output readback wrong"); // R7

   property p_idle_rdata;
      @(posedge ref_clk) disable iff (rst)
         !rd |=> bus_rdata == 16'h0000;
   endproperty
   a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read cycle"); // R8

   property p_unmapped_read;
      @(posedge ref_clk) disable iff (rst)
         (rd && bus_req.addr != `PGPIO_OFS_DAT1 && bus_req.addr != `PGPIO_OFS_EN2
            && bus_req.addr != `PGPIO_OFS_DIR2 && bus_req.addr != `PGPIO_OFS_DAT2) |=> bus_rdata == 16'h0000;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // R9
endmodule
`default_nettype wire

/* dv/pgpio_pin_model.sv */
// pin-side model for the upper-bank gpio block
`timescale 1ns/1ps
`default_nettype none
module pgpio_pin_model (
   input  wire logic [15:0] lvl1,
   input  wire logic [15:0] o1,
   input  wire logic [15:0] oe1,
   input  wire logic [13:0] lvl2,
   input  wire logic [13:0] o2,
   input  wire logic [13:0] oe2,
   output logic [15:0]      pin1,
   output logic [13:0]      pin2
);
   // driven bits read back the device level, others the outside level
   assign pin1 = (o1 & oe1) | (lvl1 & ~oe1);
   assign pin2 = (o2 & oe2) | (lvl2 & ~oe2);
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the upper-bank gpio block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {logic [15:0] a; logic [15:0] d; logic [15:0] e;} pgpio_row_t;
   logic                  ref_clk;
   logic                  rst;
   pgpio_pkg::pgpio_req_t req;
   logic [15:0]           rdata, o1, oe1, pin1, lvl1, oe_cfg, v;
   logic [13:0]           o2, oe2, pin2, lvl2;
   int                    mismatches, comparisons, cycles;
   pgpio_row_t            rows [6];
   pgpio_upper u_dut (.ref_clk(ref_clk), .rst(rst), .bus_req(req), .bus_rdata(rdata),
      .bank1_pin_i(pin1), .bank1_pin_o(o1), .bank1_pin_oe(oe1), .bank2_pin_i(pin2),
      .bank2_pin_o(o2), .bank2_pin_oe(oe2), .bank1_oe_cfg(oe_cfg), .bank1_dir_cfg(oe_cfg));
   pgpio_pin_model u_pins (.lvl1(lvl1), .o1(o1), .oe1(oe1), .lvl2(lvl2), .o2(o2), .oe2(oe2),
      .pin1(pin1), .pin2(pin2));
   task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic complete_run;
      if (mismatches == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches = mismatches + 1;
         complete_run();
      end
   end
   initial begin
      req = '0;
      rst = 1'b1;
      lvl1 = 16'hA5C3;
      lvl2 = 14'h2AAA;
      oe_cfg = 16'h0000;
      mismatches = 0;
      comparisons = 0;
      cycles = 0;
      rows = '{'{16'h4406, 16'hC003, 16'hC003}, '{16'h4407, 16'hC003, 16'hC003},
               '{16'h4408, 16'h4001, 16'h6AA9}, '{16'h4405, 16'h1234, 16'hA534},
               '{16'h4409, 16'hFFFF, 16'h0000}, '{16'h4403, 16'hFFFF, 16'h0000}};
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rd_reg(16'h4406, v);
      check("enable2", v, 16'h0000);
      rd_reg(16'h4407, v);
      check("direction2", v, 16'h0000);
      rd_reg(16'h4408, v);
      check("level2", v, 16'h2AAA);
      rd_reg(16'h4405, v);
      check("level1", v, 16'hA5C3);
      @(posedge ref_clk);
      oe_cfg <= 16'h00FF;
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         rd_reg(rows[i].a, v);
         check("row", v, rows[i].e);
      end
      check("oe2", {2'h0, oe2}, 16'h0003);
      check("o2", {14'h0000, o2[1:0]}, 16'h0001);
      check("o1", {8'h00, o1[7:0]}, 16'h0034);
      check("oe1", oe1, 16'h00FF);
      // read issued with the pin change still inside the synchroniser
      @(posedge ref_clk);
      lvl2 <= 14'h1555;
      req <= '{16'h4408, 16'h0000, 1'b0, 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1;
      check("sync_old", rdata, 16'h6AA9);
      repeat (4) @(posedge ref_clk);
      rd_reg(16'h4408, v);
      check("sync_new", v, 16'h5555);
      @(posedge ref_clk);
      #1;
      check("rdata_idle", rdata, 16'h0000);
      // second reset in mid-run with bank1 released to the outside level
      @(posedge ref_clk);
      rst <= 1'b1;
      oe_cfg <= 16'h0000;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      check("oe2_reset", {2'h0, oe2}, 16'h0000);
      rd_reg(16'h4406, v);
      check("enable2_rst", v, 16'h0000);
      rd_reg(16'h4407, v);
      check("direction2_rst", v, 16'h0000);
      rd_reg(16'h4408, v);
      check("level2_rst", v, 16'h1555);
      rd_reg(16'h4405, v);
      check("level1_rst", v, 16'hA5C3);
      complete_run();
   end
endmodule
`default_nettype wire
